// file: src/mces_pkg.sv
// Constants and types of the channel event select block
package mces_pkg;

    // ----------------------------------------------------------------
    // Register map (byte addresses)
    // ----------------------------------------------------------------
    localparam int         NCTR        = 4;
    localparam int         CTR_W       = 48;
    localparam logic [7:0] OFF_CTR_LO0 = 8'hA0;
    localparam logic [7:0] CTR_STEP    = 8'h08;
    localparam logic [7:0] OFF_CTL0    = 8'hD8;
    localparam logic [7:0] CTL_STEP    = 8'h04;

    // ----------------------------------------------------------------
    // Control fields and reset values
    // ----------------------------------------------------------------
    localparam int          EV_LSB    = 0;
    localparam int          UM_LSB    = 8;
    localparam int          EDGE_BIT  = 18;
    localparam int          EN_BIT    = 22;
    localparam int          INV_BIT   = 23;
    localparam int          TH_LSB    = 24;
    localparam logic [31:0] CTL_RESET = 32'h0000_0000;
    localparam logic [47:0] CTR_RESET = 48'h0000_0000_0000;
    localparam logic [47:0] CTR_ONE   = 48'h0000_0000_0001;

    // ----------------------------------------------------------------
    // Event codes and sub-event masks
    // ----------------------------------------------------------------
    localparam logic [7:0] EV_ACT     = 8'h01;
    localparam logic [7:0] EV_CAS     = 8'h04;
    localparam logic [7:0] EV_REF     = 8'h05;
    localparam logic [7:0] EV_PREALL  = 8'h06;
    localparam logic [7:0] EV_MAJOR   = 8'h07;
    localparam logic [7:0] EV_ECC     = 8'h09;
    localparam logic [7:0] EV_CKE     = 8'h83;
    localparam logic [7:0] EV_SLOWPD  = 8'h84;
    localparam logic [7:0] EV_PPD     = 8'h85;
    localparam logic [7:0] EV_CRIT    = 8'h86;
    localparam int         CAS_RD     = 0;
    localparam int         CAS_UF     = 1;
    localparam int         CAS_WWM    = 2;
    localparam int         CAS_WRM    = 3;
    localparam int         REF_URG    = 1;
    localparam int         REF_HIGH   = 2;
    localparam logic [7:0] MASK_ALLRD = 8'h03;
    localparam logic [7:0] MASK_ALLWR = 8'h0C;
    localparam logic [7:0] MASK_ALL   = 8'h0F;

    // ----------------------------------------------------------------
    // Correction limits in bits
    // ----------------------------------------------------------------
    localparam logic [3:0] ECC_LIM_IND  = 4'h4;
    localparam logic [3:0] ECC_LIM_LOCK = 4'h8;

    typedef enum logic [1:0] {
        MM_READ    = 2'b00,
        MM_WRITE   = 2'b01,
        MM_PARTIAL = 2'b10,
        MM_ISOCH   = 2'b11
    } mces_mode_e;

    function automatic logic [3:0] mode_onehot(input mces_mode_e m);
        logic [3:0] r;
        r = 4'h0;
        case (m)
            MM_READ:    r = 4'h1;
            MM_WRITE:   r = 4'h2;
            MM_PARTIAL: r = 4'h4;
            MM_ISOCH:   r = 4'h8;
            default:    r = 4'h0;
        endcase
        return r;
    endfunction

endpackage

// file: src/mces_mode_if.sv
// Major mode request and state carrier
interface mces_mode_if;
    logic                  wpq_high;
    logic                  uf_starved;
    logic                  isoch_present;
    mces_pkg::mces_mode_e  mode;

    modport top (output wpq_high, uf_starved, isoch_present, input mode);
    modport fsm (input wpq_high, uf_starved, isoch_present, output mode);
endinterface

// file: src/mces_major_mode.sv
// Channel-wide major mode selector
module mces_major_mode (
    // Clock and reset
    input  wire logic  ref_clk,
    input  wire logic  rst_n,
    // Mode requests and state
    mces_mode_if.fsm   mif
);

    typedef struct packed {
        mces_pkg::mces_mode_e mode;
    } mces_mm_s;

    mces_mm_s st;
    mces_mm_s next_st;

    // ----------------------------------------------------------------
    // Mode choice
    // ----------------------------------------------------------------
    // Isoch outranks the underfill drain, which outranks write pressure
    always_comb
    begin
        next_st = st;
        if (mif.isoch_present)
            next_st.mode = mces_pkg::MM_ISOCH;     // see R14
        else if (mif.uf_starved)
            next_st.mode = mces_pkg::MM_PARTIAL;   // see R13
        else if (mif.wpq_high)
            next_st.mode = mces_pkg::MM_WRITE;     // see R12
        else
            next_st.mode = mces_pkg::MM_READ;      // see R11
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            st <= '{mode: mces_pkg::MM_READ};
        else
            st <= next_st;
    end

    assign mif.mode = st.mode;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    isoch_entry_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // see R14
        mif.isoch_present |=> st.mode == mces_pkg::MM_ISOCH)
        else $error("isoch mode not entered");
    write_entry_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // see R12
        mif.wpq_high && !mif.isoch_present && !mif.uf_starved
        |=> st.mode == mces_pkg::MM_WRITE)
        else $error("write mode not entered");
    read_default_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // see R11
        !(mif.wpq_high || mif.isoch_present || mif.uf_starved)
        |=> st.mode == mces_pkg::MM_READ)
        else $error("read mode not default");

endmodule

// file: src/mces_top.sv
// Channel event select, counters and register slave
//
// Notes on behaviour
// R1: Activate code counts one per activate command on the channel.
// R2: Column code mask bit 0 counts every read CAS, mode ignored.
// R3: Column code mask bit 1 counts underfill reads in any mode.
// R4: Bit 2 counts write CAS in write mode, bit 3 in read mode.
// R5: Masks 03 all reads, 0C all writes, 0F every CAS; write CAS in partial or isoch mode is not counted.
// R6: Precharge-all code counts each precharge-all command once.
// R7: Refresh code: bit 1 urgent refreshes, bit 2 high refreshes.
// R8: Corrected-error code counts once per correction, any bit count.
// R9: Corrections reach four bits independent, eight bits lockstep.
// R10: Major-mode code counts cycles in mask-chosen mode.
// R11: Read priority mode is the default.
// R12: High write queue occupancy enters write priority mode.
// R13: Partial mode drains starved underfill reads only.
// R14: Any isochronous transaction forces isochronous mode.
// R15: Slow power-down code counts cycles with all ranks slow.
// R16: Precharge power-down code counts cycles with all ranks in it.
// R17: Clock-enable code picks ranks by mask, adds one at most.
// R18: Software should not combine invert with edge detect here.
// R19: Critical throttle code counts throttle cycles, no rank filter.
// R20: Every event works on any of the four counters.
// R21: Event code in control bits 7:0, mask in bits 15:8.
// R22: Counters are 48 bits and wrap, counting on.
// R23: Increment compared with 8-bit threshold in bits 31:24.
// R24: A mask selecting no defined sub-event gives zero increment; codes 01, 06, 09, 84, 85 and 86 ignore the mask.
//
// Local design decisions: the Wishbone slave port and the address map.
module mces_top (
    // Clock and reset
    input  wire logic         ref_clk,
    input  wire logic         rst_n,
    // Wishbone slave
    input  wire logic         wb_cyc_i,
    input  wire logic         wb_stb_i,
    input  wire logic         wb_we_i,
    input  wire logic [7:0]   wb_adr_i,
    input  wire logic [3:0]   wb_sel_i,
    input  wire logic [31:0]  wb_dat_i,
    output logic      [31:0]  wb_dat_o,
    output logic              wb_ack_o,
    // Channel commands
    input  wire logic         activate_cmd,
    input  wire logic         read_cas,
    input  wire logic         underfill_read,
    input  wire logic         write_cas,
    input  wire logic         precharge_all_cmd,
    input  wire logic         refresh_issued,
    input  wire logic         urgent_refresh,
    input  wire logic         high_refresh,
    // Error correction
    input  wire logic         ecc_fix_valid,
    input  wire logic [3:0]   ecc_fix_bits,
    input  wire logic         lockstep_mode,
    output logic              ecc_uncorrectable,
    // Mode requests
    input  wire logic         write_pending_queue_high,
    input  wire logic         underfill_starved,
    input  wire logic         isoch_present,
    output logic      [3:0]   major_mode_onehot,
    // Rank power state
    input  wire logic [7:0]   rank_cke_on,
    input  wire logic [7:0]   rank_slow_pd,
    input  wire logic [7:0]   rank_precharge_power_down,
    input  wire logic         critical_throttle
);

    typedef struct packed {
        logic [3:0][31:0] ctl;
        logic [3:0][47:0] cnt;
        logic [3:0]       prev;
        logic             ack;
        logic [31:0]      rdat;
        logic             ecc_bad;
        logic [3:0]       mode_oh;
    } mces_state_s;

    mces_state_s st;
    mces_state_s next_st;
    mces_mode_if mif ();
    logic [3:0]  inc;
    logic        req;
    logic        ecc_ok;
    logic        plain0;

    // ----------------------------------------------------------------
    // Major mode selector
    // ----------------------------------------------------------------
    assign mif.wpq_high      = write_pending_queue_high;
    assign mif.uf_starved    = underfill_starved;
    assign mif.isoch_present = isoch_present;

    mces_major_mode u_mode (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .mif     (mif)
    );

    // ----------------------------------------------------------------
    // Event selection
    // ----------------------------------------------------------------
    // Counts only what the checker accepted as correctable
    assign ecc_ok = ecc_fix_valid && (ecc_fix_bits <= (lockstep_mode ?
        mces_pkg::ECC_LIM_LOCK : mces_pkg::ECC_LIM_IND));   // see R9

    function automatic logic ev_inc(input logic [7:0] code,
                                    input logic [7:0] m);
        logic r;
        logic read_priority_mode;
        r = 1'b0;
        read_priority_mode = (mif.mode == mces_pkg::MM_READ);
        case (code)
            mces_pkg::EV_ACT:    r = activate_cmd;           // see R1
            mces_pkg::EV_CAS:                                // see R5
                r = (m[mces_pkg::CAS_RD] && read_cas) ||     // see R2
                    (m[mces_pkg::CAS_UF] && underfill_read) || // see R3
                    (m[mces_pkg::CAS_WWM] && write_cas &&
                     mif.mode == mces_pkg::MM_WRITE) ||      // see R4
                    (m[mces_pkg::CAS_WRM] && write_cas && read_priority_mode);
            mces_pkg::EV_REF:                                // see R7
                r = refresh_issued &&
                    ((m[mces_pkg::REF_URG] && urgent_refresh) ||
                     (m[mces_pkg::REF_HIGH] && high_refresh));
            mces_pkg::EV_PREALL: r = precharge_all_cmd;      // see R6
            mces_pkg::EV_MAJOR:                              // see R10
                r = |(m[3:0] & mces_pkg::mode_onehot(mif.mode));
            mces_pkg::EV_ECC:    r = ecc_ok;                 // see R8
            mces_pkg::EV_CKE:    r = |(m & rank_cke_on);     // see R17
            mces_pkg::EV_SLOWPD: r = &rank_slow_pd;          // see R15
            mces_pkg::EV_PPD:                                // see R16
                r = &rank_precharge_power_down;
            mces_pkg::EV_CRIT:   r = critical_throttle;      // see R19
            default:             r = 1'b0;
        endcase
        return r;                                            // see R24
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] d,
                                          input logic [3:0]  sel);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++)
            if (sel[b])
                r[b*8 +: 8] = d[b*8 +: 8];
        return r;
    endfunction

    always_comb
    begin
        for (int i = 0; i < mces_pkg::NCTR; i++)             // see R20
            inc[i] = ev_inc(st.ctl[i][mces_pkg::EV_LSB +: 8],
                            st.ctl[i][mces_pkg::UM_LSB +: 8]); // see R21
    end

    // ----------------------------------------------------------------
    // Counters and register access
    // ----------------------------------------------------------------
    assign req = wb_cyc_i && wb_stb_i && !st.ack;

    always_comb
    begin
        logic        cmp;
        logic        hit;
        logic [7:0]  th;
        logic [7:0]  a;
        logic [47:0] c;
        cmp = 1'b0;
        hit = 1'b0;
        th = 8'h00;
        a = 8'h00;
        c = mces_pkg::CTR_RESET;
        next_st = st;
        next_st.ack = req;
        next_st.ecc_bad = ecc_fix_valid && !ecc_ok;
        next_st.mode_oh = mces_pkg::mode_onehot(mif.mode);
        for (int i = 0; i < mces_pkg::NCTR; i++)
        begin
            th = st.ctl[i][mces_pkg::TH_LSB +: 8];
            cmp = st.ctl[i][mces_pkg::INV_BIT] ? ({7'h00, inc[i]} < th)
                                               : ({7'h00, inc[i]} >= th);
            // Edge detect follows the threshold stage, not the raw event
            hit = st.ctl[i][mces_pkg::EDGE_BIT] ? (cmp && !st.prev[i])
                                                : cmp;       // see R23
            next_st.prev[i] = cmp;
            if (st.ctl[i][mces_pkg::EN_BIT] && hit)
                next_st.cnt[i] = st.cnt[i] + mces_pkg::CTR_ONE; // see R22
        end
        if (req)
        begin
            next_st.rdat = 32'h0000_0000;
            for (int i = 0; i < mces_pkg::NCTR; i++)
            begin
                a = mces_pkg::OFF_CTL0 + 8'(i * 4);
                if (wb_adr_i == a)
                begin
                    next_st.rdat = st.ctl[i];
                    if (wb_we_i)
                        next_st.ctl[i] = merge(st.ctl[i], wb_dat_i,
                                               wb_sel_i);
                end
                a = mces_pkg::OFF_CTR_LO0 + 8'(i * 8);
                c = st.cnt[i];
                if (wb_adr_i == a)
                begin
                    next_st.rdat = c[31:0];
                    if (wb_we_i)
                        next_st.cnt[i][31:0] = merge(c[31:0], wb_dat_i,
                                                     wb_sel_i);
                end
                if (wb_adr_i == a + mces_pkg::CTL_STEP)
                begin
                    next_st.rdat = {16'h0000, c[47:32]};
                    if (wb_we_i)
                        next_st.cnt[i][47:32] = 16'(merge(
                            {16'h0000, c[47:32]}, wb_dat_i, wb_sel_i));
                end
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st.ctl     <= {mces_pkg::NCTR{mces_pkg::CTL_RESET}};
            st.cnt     <= {mces_pkg::NCTR{mces_pkg::CTR_RESET}};
            st.prev    <= 4'h0;
            st.ack     <= 1'b0;
            st.rdat    <= 32'h0000_0000;
            st.ecc_bad <= 1'b0;
            st.mode_oh <= 4'h1;
        end
        else
            st <= next_st;
    end

    assign wb_dat_o          = st.rdat;
    assign wb_ack_o          = st.ack;
    assign ecc_uncorrectable = st.ecc_bad;
    assign major_mode_onehot = st.mode_oh;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    // Counter 0 in plain counting: enabled, threshold one, no shaping
    assign plain0 = st.ctl[0][mces_pkg::EN_BIT] &&
                    st.ctl[0][mces_pkg::TH_LSB +: 8] == 8'h01 &&
                    !st.ctl[0][mces_pkg::INV_BIT] &&
                    !st.ctl[0][mces_pkg::EDGE_BIT];

    sequence s_idle_count;
        plain0 && inc[0] && !req;
    endsequence

    bus_ack_a: assert property (req |=> wb_ack_o ##1 !wb_ack_o)
        else $error("ack not one cycle after request");
    count_step_a: assert property (s_idle_count |=> // see R22
        st.cnt[0] == $past(st.cnt[0]) + mces_pkg::CTR_ONE)
        else $error("counter did not advance");
    count_wrap_a: assert property ((s_idle_count and // see R22
        (&st.cnt[0])) |=> st.cnt[0] == mces_pkg::CTR_RESET)
        else $error("counter did not wrap");
    act_select_a: assert property (st.ctl[0][7:0] == mces_pkg::EV_ACT // see R1
        |-> inc[0] == activate_cmd)
        else $error("activate event wrong");
    all_reads_a: assert property (st.ctl[0][15:0] == // see R5
        {mces_pkg::MASK_ALLRD, mces_pkg::EV_CAS}
        |-> inc[0] == (read_cas || underfill_read))
        else $error("read CAS selection wrong");
    all_writes_a: assert property (st.ctl[0][15:0] == // see R4
        {mces_pkg::MASK_ALLWR, mces_pkg::EV_CAS} && write_cas &&
        (mif.mode == mces_pkg::MM_READ || mif.mode == mces_pkg::MM_WRITE)
        |-> inc[0])
        else $error("write CAS not counted");
    empty_mask_a: assert property (st.ctl[0][15:8] == 8'h00 && // see R24
        st.ctl[0][7:0] != mces_pkg::EV_ACT &&
        st.ctl[0][7:0] != mces_pkg::EV_PREALL &&
        st.ctl[0][7:0] != mces_pkg::EV_ECC &&
        st.ctl[0][7:0] < mces_pkg::EV_SLOWPD |-> !inc[0])
        else $error("empty mask counted");
    ecc_limit_a: assert property (ecc_fix_valid && !lockstep_mode && // see R9
        ecc_fix_bits > mces_pkg::ECC_LIM_IND |=> ecc_uncorrectable)
        else $error("too many bits not flagged");
    slow_all_a: assert property (st.ctl[1][7:0] == mces_pkg::EV_SLOWPD // see R15
        |-> inc[1] == (&rank_slow_pd))
        else $error("slow power-down wrong");
    cke_rank_a: assert property (st.ctl[2][7:0] == mces_pkg::EV_CKE && // see R17
        |(st.ctl[2][15:8] & rank_cke_on) |-> inc[2])
        else $error("rank clock-enable missed");
    mode_out_a: assert property (isoch_present |=> ##1 // see R14
        major_mode_onehot == 4'h8)
        else $error("isoch mode not shown");

endmodule

// file: testbench/mces_chan_model.sv
// Channel activity source: one fixed eight-cycle burst per go pulse
module mces_chan_model (
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        rst_n,
    // Burst start
    input  wire logic        go,
    // Channel activity
    output logic             activate_cmd,
    output logic             read_cas,
    output logic             underfill_read,
    output logic             write_cas,
    output logic             precharge_all_cmd,
    output logic             refresh_issued,
    output logic             urgent_refresh,
    output logic             high_refresh,
    output logic             ecc_fix_valid,
    output logic      [3:0]  ecc_fix_bits,
    output logic      [7:0]  rank_cke_on,
    output logic      [7:0]  rank_slow_pd,
    output logic      [7:0]  rank_precharge_power_down,
    output logic             critical_throttle
);
    timeunit 1ns;
    timeprecision 1ps;

    logic       run;
    logic [2:0] step;

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            run  <= 1'h0;
            step <= 3'h0;
        end
        else
        begin
            run  <= go | (run & (step != 3'h7));
            step <= go ? 3'h0 : step + 3'h1;
        end
    end

    // Qualifiers and bit counts wander when not qualified, on purpose
    always_comb
    begin
        activate_cmd      = run & (step < 3'h2 || step == 3'h5);
        read_cas          = run & (step == 3'h0 || step == 3'h2);
        underfill_read    = run & (step == 3'h3);
        write_cas         = run & (step == 3'h4);
        precharge_all_cmd = run & (step == 3'h6);
        refresh_issued    = run & (step >= 3'h1 && step <= 3'h3);
        urgent_refresh    = refresh_issued ? step == 3'h1 : step[0];
        high_refresh      = refresh_issued ? step >= 3'h2 : ~step[0];
        ecc_fix_valid     = run & (step <= 3'h2);
        ecc_fix_bits      = !ecc_fix_valid ? {1'h1, step} :
                            step == 3'h0 ? 4'h1 :
                            step == 3'h1 ? 4'h4 : 4'h5;
        rank_cke_on       = !run ? 8'h00 : step <= 3'h3 ? 8'h03 :
                            step == 3'h4 ? 8'h80 : 8'h00;
        rank_slow_pd      = !run ? 8'h00 : step <= 3'h1 ? 8'hFF :
                            step == 3'h2 ? 8'h7F : 8'h00;
        rank_precharge_power_down = !run ? 8'h00 :
                            (step >= 3'h3 && step <= 3'h5) ? 8'hFF :
                            step == 3'h6 ? 8'hFE : 8'h00;
        critical_throttle = run & (step >= 3'h2 && step <= 3'h6);
    end
endmodule

// file: testbench/tb.sv
// Self-checking bench for the channel event select block
module tb;
    timeunit 1ns;
    timeprecision 1ps;

    logic        ref_clk = 1'h0;
    logic        rst_n = 1'h0;
    logic        wb_cyc_i = 1'h0;
    logic        wb_stb_i = 1'h0;
    logic        wb_we_i = 1'h0;
    logic [7:0]  wb_adr_i = 8'h00;
    logic [3:0]  wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0;
    logic [31:0] wb_dat_o;
    logic        wb_ack_o;
    logic        go = 1'h0;
    logic        lockstep_mode = 1'h0;
    logic        write_pending_queue_high = 1'h0;
    logic        underfill_starved = 1'h0;
    logic        isoch_present = 1'h0;
    logic        ecc_uncorrectable;
    logic [3:0]  major_mode_onehot;
    logic        activate_cmd, read_cas, underfill_read, write_cas;
    logic        precharge_all_cmd, refresh_issued, urgent_refresh;
    logic        high_refresh, ecc_fix_valid, critical_throttle;
    logic [3:0]  ecc_fix_bits;
    logic [7:0]  rank_cke_on, rank_slow_pd, rank_precharge_power_down;
    logic [31:0] q;
    int          failures = 0;
    int          n_compared = 0;
    int          n_unc = 0;
    int          k = 0;

    always #2.5 ref_clk = ~ref_clk;

    always @(posedge ref_clk)
        if (ecc_uncorrectable === 1'h1)
            n_unc++;

    mces_top u_dut (
        .ref_clk, .rst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
        .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .activate_cmd,
        .read_cas, .underfill_read, .write_cas, .precharge_all_cmd,
        .refresh_issued, .urgent_refresh, .high_refresh, .ecc_fix_valid,
        .ecc_fix_bits, .lockstep_mode, .ecc_uncorrectable,
        .write_pending_queue_high, .underfill_starved, .isoch_present,
        .major_mode_onehot, .rank_cke_on, .rank_slow_pd,
        .rank_precharge_power_down, .critical_throttle
    );

    mces_chan_model u_chan (
        .ref_clk, .rst_n, .go, .activate_cmd, .read_cas, .underfill_read,
        .write_cas, .precharge_all_cmd, .refresh_issued, .urgent_refresh,
        .high_refresh, .ecc_fix_valid, .ecc_fix_bits, .rank_cke_on,
        .rank_slow_pd, .rank_precharge_power_down, .critical_throttle
    );

    // ----------------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------------
    task automatic finish_test();
        if (failures == 0 && n_compared > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [47:0] e, g);
        n_compared++;
        if (g !== e)
        begin
            $display("mismatch %s expected %h seen %h", nm, e, g);
            failures++;
        end
    endtask

    // Classic cycle; request held until ack is sampled high
    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] r);
        int n;
        n = 0;
        @(posedge ref_clk);
        wb_cyc_i <= 1'h1;
        wb_stb_i <= 1'h1;
        wb_we_i  <= w;
        wb_adr_i <= a;
        wb_sel_i <= 4'hF;
        wb_dat_i <= d;
        do
        begin
            @(posedge ref_clk);
            n++;
        end
        while (wb_ack_o !== 1'h1 && n < 50);
        r = wb_dat_o;
        wb_cyc_i <= 1'h0;
        wb_stb_i <= 1'h0;
        if (wb_ack_o !== 1'h1)
            chk("wb_ack", 48'h1, 48'h0);
    endtask

    // Counters rotate 0..3; all-ones expectation means any nonzero
    // Control word: threshold, enable bit 22, edge bit 18, mask, code
    task automatic ev(input string nm, input logic [31:0] c,
                      input logic [47:0] init, exp);
        logic [7:0]  lo;
        logic [7:0]  ct;
        logic [31:0] a;
        logic [31:0] b;
        lo = mces_pkg::OFF_CTR_LO0 + mces_pkg::CTR_STEP * 8'(k % 4);
        ct = mces_pkg::OFF_CTL0 + mces_pkg::CTL_STEP * 8'(k % 4);
        k++;
        wb(1'h1, lo, init[31:0], a);
        wb(1'h1, lo + 8'h04, {16'h0, init[47:32]}, a);
        wb(1'h1, ct, c, a);
        @(posedge ref_clk);
        go <= 1'h1;
        @(posedge ref_clk);
        go <= 1'h0;
        repeat (12) @(posedge ref_clk);
        wb(1'h1, ct, 32'h0, a);
        wb(1'h0, lo, 32'h0, a);
        wb(1'h0, lo + 8'h04, 32'h0, b);
        if (exp === 48'hFFFF_FFFF_FFFF)
            chk(nm, 48'h1, 48'(|{b[15:0], a}));
        else
            chk(nm, exp, {b[15:0], a});
    endtask

    // Mode output lags its inputs by two cycles
    task automatic lv(input logic w, s, i, l);
        @(posedge ref_clk);
        write_pending_queue_high <= w;
        underfill_starved        <= s;
        isoch_present            <= i;
        lockstep_mode            <= l;
        repeat (4) @(posedge ref_clk);
    endtask

    // ----------------------------------------------------------------
    // Tests
    // ----------------------------------------------------------------
    initial
    begin
        #100000;
        failures++;
        finish_test();
    end

    initial
    begin
        repeat (4) @(posedge ref_clk);
        rst_n <= 1'h1;
        wb(1'h0, mces_pkg::OFF_CTL0, 32'h0, q);
        chk("ctl0", 48'h0, {16'h0, q});
        chk("mode", 48'h1, 48'(major_mode_onehot));
        wb(1'h1, 8'h00, 32'hFFFF_FFFF, q);
        wb(1'h0, 8'h00, 32'h0, q);
        chk("unmapped", 48'h0, {16'h0, q});
        ev("wrap", 32'h0140_0001, '1, 48'h2);
        ev("act edge", 32'h0144_0001, 48'h0, 48'h2);
        ev("act th2", 32'h0240_0001, 48'h0, 48'h0);
        ev("act", 32'h0140_0001, 48'h0, 48'h3);
        ev("allrd", 32'h0140_0304, 48'h0, 48'h3);
        ev("rd", 32'h0140_0104, 48'h0, 48'h2);
        ev("uf", 32'h0140_0204, 48'h0, 48'h1);
        ev("unlisted", 32'h0140_FF02, 48'h0, 48'h0);
        ev("allwr", 32'h0140_0C04, 48'h0, 48'h1);
        ev("all", 32'h0140_0F04, 48'h0, 48'h4);
        ev("write_column_in_read_mode", 32'h0140_0804, 48'h0, 48'h1);
        ev("wr wmm0", 32'h0140_0404, 48'h0, 48'h0);
        lv(1'h1, 1'h0, 1'h0, 1'h0);
        chk("mode w", 48'h2, 48'(major_mode_onehot));
        ev("write_column_in_write_mode", 32'h0140_0404, 48'h0, 48'h1);
        ev("wr rmm0", 32'h0140_0804, 48'h0, 48'h0);
        ev("mm w", 32'h0140_0207, 48'h0, '1);
        ev("mm r0", 32'h0140_0107, 48'h0, 48'h0);
        lv(1'h1, 1'h1, 1'h0, 1'h0);
        chk("mode p", 48'h4, 48'(major_mode_onehot));
        ev("wr part", 32'h0140_0C04, 48'h0, 48'h0);
        ev("rd part", 32'h0140_0104, 48'h0, 48'h2);
        ev("uf part", 32'h0140_0204, 48'h0, 48'h1);
        lv(1'h1, 1'h1, 1'h1, 1'h0);
        chk("mode i", 48'h8, 48'(major_mode_onehot));
        lv(1'h0, 1'h0, 1'h1, 1'h0);
        chk("mode i2", 48'h8, 48'(major_mode_onehot));
        ev("mm i", 32'h0140_0807, 48'h0, '1);
        lv(1'h0, 1'h0, 1'h0, 1'h0);
        chk("mode r", 48'h1, 48'(major_mode_onehot));
        ev("preall", 32'h0140_0006, 48'h0, 48'h1);
        ev("ref urg", 32'h0140_0205, 48'h0, 48'h1);
        ev("ref hi", 32'h0140_0405, 48'h0, 48'h2);
        ev("ref both", 32'h0140_0605, 48'h0, 48'h3);
        ev("ref b0", 32'h0140_0105, 48'h0, 48'h0);
        n_unc = 0;
        ev("ecc ind", 32'h0140_0009, 48'h0, 48'h2);
        chk("unc ind", 48'h1, 48'(n_unc));
        lv(1'h0, 1'h0, 1'h0, 1'h1);
        n_unc = 0;
        ev("ecc lock", 32'h0140_0009, 48'h0, 48'h3);
        chk("unc lock", 48'h0, 48'(n_unc));
        ev("cke 03", 32'h0140_0383, 48'h0, 48'h4);
        ev("cke 00", 32'h0140_0083, 48'h0, 48'h0);
        ev("cke 83", 32'h0140_8383, 48'h0, 48'h5);
        ev("cke 80", 32'h0140_8083, 48'h0, 48'h1);
        ev("crit", 32'h0140_FF86, 48'h0, 48'h5);
        ev("ppd", 32'h0140_0085, 48'h0, 48'h3);
        ev("slowpd", 32'h0140_0084, 48'h0, 48'h2);
        finish_test();
    end
endmodule
